// ### rtl/sac_regs.svh
// register map, field positions, reset values and timing counts of the converter control
// How it works
// - writing one to conversion_go, with bit 4 one in the same write, starts a conversion and clears done at once
// - finishing a conversion sets done, bit 6, marking the result valid
// - one conversion per start; no automatic repeat afterwards
// - conversion_go written during a conversion abandons it and starts afresh
// - conversion_go, bit 5, is write-only and always reads zero
// - done set while interrupt enable is one raises the end-of-conversion request
// - bit 7 enables the end-of-conversion interrupt, zero masks it
// - bit 4 powers the converter; zero puts it in low-power idle
// - reset aborts conversion, loads control with 40h, masks the interrupt
// - successive approximation clocked by the system clock divided by twelve
// - result register at D0h holds the last completed 8-bit outcome
// - a conversion takes about 70us at an 8MHz oscillator
// - done is read-only and serves as interrupt pending flag
// - converter keeps running in processor wait state, no automatic disable
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

`define SAC_RESULT_ADDR 8'hD0
`define SAC_CTRL_ADDR 8'hD1
`define SAC_BIT_IRQ_EN 7
`define SAC_BIT_DONE 6
`define SAC_BIT_GO 5
`define SAC_BIT_PWR 4
`define SAC_CTRL_RESET 8'h40
`define SAC_RES_BITS 8
`define SAC_DIV_RATIO 12
`define SAC_OSC_PERIOD_NS 125
`define SAC_CONV_TIME_NS 70000
// divided clocks per result bit, nearest whole count to the typical time
`define SAC_CLKS_PER_BIT ((`SAC_CONV_TIME_NS + (`SAC_OSC_PERIOD_NS * `SAC_DIV_RATIO * \
    `SAC_RES_BITS) / 2) / (`SAC_OSC_PERIOD_NS * `SAC_DIV_RATIO * `SAC_RES_BITS))

`endif

// ### rtl/sac_pkg.sv
// types shared by the converter control modules
package sac_pkg;
    typedef enum logic [0:0] {SAC_IDLE, SAC_RUN} sac_state_t;
    typedef logic [7:0] sac_byte_t;
endpackage : sac_pkg

// ### rtl/sac_sar_if.sv
// link between the register front end and the approximation engine
`timescale 1ns/1ps
interface sac_sar_if;
    import sac_pkg::*;
    logic start;
    logic power;
    logic comp;
    logic busy;
    logic done;
    sac_byte_t result;
    sac_byte_t trial;
    modport ctl (output start, output power, output comp, input busy, input done,
        input result, input trial);
    modport eng (input start, input power, input comp, output busy, output done,
        output result, output trial);
endinterface : sac_sar_if

// ### rtl/sac_sar_engine.sv
// successive approximation engine with divide-by-twelve step enable
`timescale 1ns/1ps
`include "sac_regs.svh"
module sac_sar_engine
    import sac_pkg::*;
#(
    parameter int DIV_RATIO = `SAC_DIV_RATIO,
    parameter int CLKS_PER_BIT = `SAC_CLKS_PER_BIT
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    sac_sar_if.eng sar
);
    localparam int TOTAL = DIV_RATIO * CLKS_PER_BIT * `SAC_RES_BITS;

    // counters are 4 and 3 bits wide, so larger settings would wrap
    if (DIV_RATIO < 2 || DIV_RATIO > 15 || CLKS_PER_BIT < 1 || CLKS_PER_BIT > 8) begin
        $error("sac_sar_engine: unsupported divider or bit length");
    end

    sac_state_t state_reg, state_next;
    logic [3:0] div_reg, div_next;
    logic [2:0] sub_reg, sub_next;
    logic [2:0] bit_reg, bit_next;
    sac_byte_t trial_reg, trial_next;
    sac_byte_t result_reg, result_next;
    logic done_reg, done_next;
    logic tick;
    sac_byte_t decided;

    // divided clock: a one-cycle enable every DIV_RATIO cycles while running
    assign tick = (state_reg == SAC_RUN) && (div_reg == 4'(DIV_RATIO - 1));
    assign sar.busy = (state_reg == SAC_RUN);
    assign sar.done = done_reg;
    assign sar.result = result_reg;
    assign sar.trial = trial_reg;

    // next state; start outranks power so go and power in one write work
    always_comb begin
        state_next = state_reg;
        div_next = div_reg;
        sub_next = sub_reg;
        bit_next = bit_reg;
        trial_next = trial_reg;
        result_next = result_reg;
        done_next = 1'b0;
        decided = trial_reg;
        decided[bit_reg] = sar.comp; // keep the trial bit if input is at or above it
        if (sar.start) begin
            state_next = SAC_RUN;
            div_next = 4'h0;
            sub_next = 3'h0;
            bit_next = 3'h7;
            trial_next = 8'h80;
        end else if (!sar.power) begin
            state_next = SAC_IDLE;
        end else if (tick) begin
            div_next = 4'h0;
            if (sub_reg == 3'(CLKS_PER_BIT - 1)) begin
                sub_next = 3'h0;
                if (bit_reg == 3'h0) begin
                    result_next = decided;
                    done_next = 1'b1;
                    state_next = SAC_IDLE;
                    trial_next = decided;
                end else begin
                    bit_next = bit_reg - 3'h1;
                    trial_next = decided;
                    trial_next[bit_reg - 3'h1] = 1'b1;
                end
            end else begin
                sub_next = sub_reg + 3'h1;
            end
        end else if (state_reg == SAC_RUN) begin
            div_next = div_reg + 4'h1;
        end
    end

    // engine registers; reset stops any conversion in progress
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= SAC_IDLE;
            div_reg <= 4'h0;
            sub_reg <= 3'h0;
            bit_reg <= 3'h7;
            trial_reg <= 8'h00;
            result_reg <= 8'h00;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            div_reg <= div_next;
            sub_reg <= sub_next;
            bit_reg <= bit_next;
            trial_reg <= trial_next;
            result_reg <= result_next;
            done_reg <= done_next;
        end
    end

    // helper: cycles since the last start, read only by the checks
    logic [11:0] age_reg;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            age_reg <= 12'h000;
        end else if (sar.start) begin
            age_reg <= 12'h000;
        end else if (age_reg != 12'hFFF) begin
            age_reg <= age_reg + 12'h001;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_go;
        sar.start;
    endsequence
    sequence s_fresh;
        state_reg == SAC_RUN && bit_reg == 3'h7 && trial_reg == 8'h80 && div_reg == 4'h0;
    endsequence

    property p_restart;
        s_go |=> s_fresh;
    endproperty
    a_restart: assert property (p_restart) else $error("start did not restart");

    property p_one_shot;
        done_reg |-> state_reg == SAC_IDLE ##1 (state_reg == SAC_IDLE || $past(sar.start));
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("conversion repeated");

    property p_length;
        done_reg |-> age_reg == 12'(TOTAL);
    endproperty
    a_length: assert property (p_length) else $error("conversion length wrong");

    property p_power_idle;
        !sar.power && !sar.start |=> state_reg == SAC_IDLE;
    endproperty
    a_power_idle: assert property (p_power_idle) else $error("runs without power");

    property p_result_hold;
        !done_reg |-> $stable(result_reg);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result changed");
endmodule : sac_sar_engine

// ### rtl/sac_adc_ctrl.sv
// converter control top: data-space registers, synchroniser and engine
`timescale 1ns/1ps
`include "sac_regs.svh"
module sac_adc_ctrl
    import sac_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] addr_i,
    input wire logic wr_en_i,
    input wire logic [7:0] wr_data_i,
    input wire logic rd_en_i,
    output logic [7:0] rd_data_o,
    input wire logic comp_i,
    output logic [7:0] trial_o,
    output logic converter_power_on_o,
    output logic conv_busy_o,
    output logic irq_o
);
    sac_sar_if sar ();

    localparam sac_byte_t CTRL_RESET = `SAC_CTRL_RESET;
    logic irq_en_reg, irq_en_next;
    logic done_reg, done_next;
    logic power_reg, power_next;
    sac_byte_t rd_reg, rd_next;
    logic comp_meta_reg, comp_sync_reg;
    logic wr_ctl, go;

    // comparator is asynchronous to this clock; only the second flop is read
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            comp_meta_reg <= 1'b0;
            comp_sync_reg <= 1'b0;
        end else begin
            comp_meta_reg <= comp_i;
            comp_sync_reg <= comp_meta_reg;
        end
    end

    // decode; go only counts when the same write leaves the converter powered
    assign wr_ctl = wr_en_i && (addr_i == `SAC_CTRL_ADDR);
    assign go = wr_ctl && wr_data_i[`SAC_BIT_GO] && wr_data_i[`SAC_BIT_PWR];
    assign sar.start = go;
    assign sar.power = power_reg;
    assign sar.comp = comp_sync_reg;

    // control register and read path next values
    always_comb begin
        irq_en_next = irq_en_reg;
        power_next = power_reg;
        done_next = done_reg;
        rd_next = 8'h00;
        if (wr_ctl) begin
            irq_en_next = wr_data_i[`SAC_BIT_IRQ_EN];
            power_next = wr_data_i[`SAC_BIT_PWR];
        end
        // a finishing conversion wins over a clearing start in the same cycle
        if (sar.done) begin
            done_next = 1'b1;
        end else if (go) begin
            done_next = 1'b0;
        end
        if (rd_en_i) begin
            case (addr_i)
                `SAC_RESULT_ADDR: rd_next = sar.result;
                // go reads zero and bits 3-0 read zero
                `SAC_CTRL_ADDR: rd_next = {irq_en_reg, done_reg, 1'b0, power_reg, 4'h0};
                default: rd_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_en_reg <= CTRL_RESET[`SAC_BIT_IRQ_EN];
            done_reg <= CTRL_RESET[`SAC_BIT_DONE];
            power_reg <= CTRL_RESET[`SAC_BIT_PWR];
            rd_reg <= 8'h00;
        end else begin
            irq_en_reg <= irq_en_next;
            done_reg <= done_next;
            power_reg <= power_next;
            rd_reg <= rd_next;
        end
    end

    sac_sar_engine #(
        .DIV_RATIO(`SAC_DIV_RATIO),
        .CLKS_PER_BIT(`SAC_CLKS_PER_BIT)
    ) u_engine (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .sar(sar.eng)
    );

    assign rd_data_o = rd_reg;
    assign trial_o = sar.trial;
    assign converter_power_on_o = power_reg;
    assign conv_busy_o = sar.busy;
    // level request; done doubles as pending flag
    assign irq_o = irq_en_reg && done_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_go_clears;
        go && !sar.done |=> !done_reg;
    endproperty
    a_go_clears: assert property (p_go_clears) else $error("start left done set");

    property p_done_sets;
        sar.done |=> done_reg;
    endproperty
    a_done_sets: assert property (p_done_sets) else $error("done not set");

    property p_ctrl_read;
        rd_en_i && addr_i == `SAC_CTRL_ADDR |=> rd_data_o[5:0] == {1'b0, $past(power_reg), 4'h0};
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

    property p_irq_raise;
        sar.done && irq_en_reg && !wr_ctl |=> irq_o;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("no interrupt request");

    property p_irq_mask;
        wr_ctl && !wr_data_i[`SAC_BIT_IRQ_EN] |=> !irq_o;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked request seen");

    property p_result_read;
        rd_en_i && addr_i == `SAC_RESULT_ADDR && !sar.done |=> rd_data_o == $past(sar.result);
    endproperty
    a_result_read: assert property (p_result_read) else $error("result read wrong");
endmodule : sac_adc_ctrl

// ### verif/sac_analog_model.sv
// comparator and single analog channel on the far side of the converter
`timescale 1ns/1ps
module sac_analog_model
    import sac_pkg::*;
(
    input wire logic clk_i,
    input wire sac_byte_t level_i,
    input wire sac_byte_t trial_i,
    input wire logic power_i,
    output logic comp_o
);
    logic wobble = 1'b0;
    // unpowered comparator gives no settled answer, so it flips every cycle
    always @(posedge clk_i) begin
        wobble <= ~wobble;
    end
    // one selected input only; high when the input is at or above the trial code
    assign comp_o = power_i ? (level_i >= trial_i) : wobble;
endmodule : sac_analog_model

// ### verif/tb_sac_adc_ctrl.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_sac_adc_ctrl;
    import sac_pkg::*;
    localparam int CONV = 12 * 6 * 8;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic wr_en_i = 1'b0;
    logic [7:0] wr_data_i = 8'h00;
    logic rd_en_i = 1'b0;
    logic [7:0] rd_data_o;
    logic [7:0] trial_o;
    logic comp_i;
    logic converter_power_on_o;
    logic conv_busy_o;
    logic irq_o;
    sac_byte_t level = 8'h00;
    int err_count = 0;
    int checked = 0;
    int n;
    // free-running 100 MHz clock
    always #5 clk_i = ~clk_i;
    sac_adc_ctrl i_sac_adc_ctrl (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
        .wr_en_i(wr_en_i), .wr_data_i(wr_data_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
        .comp_i(comp_i), .trial_o(trial_o), .converter_power_on_o(converter_power_on_o),
        .conv_busy_o(conv_busy_o), .irq_o(irq_o));
    sac_analog_model i_sac_analog_model (.clk_i(clk_i), .level_i(level), .trial_i(trial_o),
        .power_i(converter_power_on_o), .comp_o(comp_i));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one-cycle write strobe; returns just after the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_en_i <= 1'b1;
        @(posedge clk_i);
        wr_en_i <= 1'b0;
        #1;
    endtask : wr
    // read data is registered, so it is looked at just after the taking edge
    task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_en_i <= 1'b1;
        @(posedge clk_i);
        rd_en_i <= 1'b0;
        #1;
        chk(what, exp, rd_data_o);
    endtask : rd
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask : cyc
    // bounded wait for the end of a conversion; ahead is edges already spent since the start
    task automatic wait_idle(input int ahead);
        n = ahead;
        while (conv_busy_o !== 1'b0) begin
            cyc(1);
            n++;
            if (n > 700) begin
                chk("busy", 8'h00, 8'h01);
                report_and_stop();
            end
        end
        chk("length", 8'h01, {7'h0, n inside {[CONV:CONV + 1]}});
        cyc(2);
    endtask : wait_idle
    task automatic t_reset;
        rd("control", 8'hD1, 8'h40);
        rd("result", 8'hD0, 8'h00);
        chk("irq", 8'h00, {7'h0, irq_o});
        chk("power", 8'h00, {7'h0, converter_power_on_o});
    endtask : t_reset
    task automatic t_single;
        level <= 8'hA5;
        wr(8'hD1, 8'h10);
        wr(8'hD1, 8'hB0);
        chk("busy", 8'h01, {7'h0, conv_busy_o});
        chk("trial", 8'h80, trial_o);
        chk("irq", 8'h00, {7'h0, irq_o});
        rd("control", 8'hD1, 8'h90);
        wait_idle(2);
        rd("result", 8'hD0, 8'hA5);
        rd("control", 8'hD1, 8'hD0);
        chk("irq", 8'h01, {7'h0, irq_o});
        cyc(40);
        chk("busy", 8'h00, {7'h0, conv_busy_o});
    endtask : t_single
    task automatic t_mask;
        wr(8'hD1, 8'h10);
        chk("irq", 8'h00, {7'h0, irq_o});
        rd("control", 8'hD1, 8'h50);
        wr(8'hD0, 8'h00);
        rd("result", 8'hD0, 8'hA5);
        rd("unmapped", 8'h55, 8'h00);
    endtask : t_mask
    // second start mid-run must give a full-length conversion from itself
    task automatic t_restart;
        level <= 8'h3C;
        wr(8'hD1, 8'h30);
        cyc(200);
        wr(8'hD1, 8'h30);
        wait_idle(0);
        rd("result", 8'hD0, 8'h3C);
        rd("control", 8'hD1, 8'h50);
    endtask : t_restart
    task automatic t_power_off;
        wr(8'hD1, 8'h30);
        cyc(100);
        wr(8'hD1, 8'h00);
        cyc(2);
        chk("busy", 8'h00, {7'h0, conv_busy_o});
        chk("power", 8'h00, {7'h0, converter_power_on_o});
        rd("control", 8'hD1, 8'h00);
        rd("result", 8'hD0, 8'h3C);
        wr(8'hD1, 8'h20);
        chk("busy", 8'h00, {7'h0, conv_busy_o});
    endtask : t_power_off
    task automatic t_reset_mid;
        wr(8'hD1, 8'hB0);
        cyc(50);
        chk("busy", 8'h01, {7'h0, conv_busy_o});
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        #1;
        chk("busy", 8'h00, {7'h0, conv_busy_o});
        rd("control", 8'hD1, 8'h40);
        rd("result", 8'hD0, 8'h00);
        chk("irq", 8'h00, {7'h0, irq_o});
    endtask : t_reset_mid
    initial begin
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_single();
        t_mask();
        t_restart();
        t_power_off();
        t_reset_mid();
        report_and_stop();
    end
endmodule : tb_sac_adc_ctrl
